// >>> bench/tcr_pad_model.sv
// behavioural sensor pad: oscillates while attached, powered and not charging, period 2*half_cycles
`timescale 1ns/10ps
module tcr_pad_model (
  input  wire logic       pclk,
  input  wire logic       pad_analog,
  input  wire logic [1:0] osc_current,
  input  wire logic       pad_charge,
  input  wire logic [7:0] half_cycles,
  output logic            osc_in
);
  logic [8:0] cnt;
  logic [8:0] nxt;

  assign nxt = (cnt == {half_cycles, 1'b0} - 9'h001) ? 9'h000 : cnt + 9'h001;

  initial begin
    cnt = 9'h000;
    osc_in = 1'b0;
  end

  // no oscillation while detached, unpowered or charging
  always @(posedge pclk) begin
    if (pad_analog !== 1'b1 || osc_current === 2'b00 || pad_charge === 1'b1) begin
      cnt <= 9'h000;
      osc_in <= 1'b0;
    end else begin
      cnt <= nxt;
      osc_in <= (nxt >= {1'b0, half_cycles});
    end
  end
endmodule

// >>> bench/tcr_touch_readout_tb.sv
// self-checking bench for the capacitive touch readout
`timescale 1ns/10ps
module tcr_touch_readout_tb;
  typedef struct {
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] chg;
    logic [1:0]  cur;
    logic [2:0]  chan;
  } tcr_exp_t;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, osc_in;
  logic        pad_analog, pad_charge, busy, done, err, dprev;
  logic [7:0]  paddr, half;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] result, chg_n;
  logic [2:0]  pad_chan, chan_seen;
  logic [1:0]  osc_current, cur_seen;
  logic [2:0]  pre [5];
  logic [7:0]  chg_cfg [4];
  int          n_errors, checks;
  tcr_exp_t    q[$];
  tcr_exp_t    me;

  tcr_touch_readout uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .osc_in, .pad_analog, .pad_chan, .osc_current, .pad_charge,
    .busy, .done, .result);
  tcr_pad_model pad (.pclk, .pad_analog, .osc_current, .pad_charge, .half_cycles(half),
    .osc_in);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input logic [15:0] lo, hi, g);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_errors++;
      $display("mismatch %s expected %0h..%0h seen %0h", nm, lo, hi, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  task automatic measure(input logic v, u, input logic [7:0] c, h, input logic poke);
    tcr_exp_t e;
    logic [7:0] k;
    int r, t, w;
    k = u ? c : (v ? tcr_pkg::CFG_DEF_CHG : tcr_pkg::CFG_DEF_WORD);
    half <= h;
    apb(1'b1, tcr_pkg::ADDR_CFG, {24'h000000, c});
    e.chan = 3'($urandom);
    if (!v) begin
      r = (256 - 32 * int'(k[7:5])) * 2 * int'(h);
      r = r >> (int'(k[2:0]) + 1);
      e.cur = k[4:3];
      e.chg = 16'h0000;
    end else begin
      t = (k[3:0] == 4'h0) ? 1 : int'(k[3:0]);
      e.chg = 16'(t * tcr_pkg::CYC_UNIT);
      e.cur = k[5:4];
      r = (e.cur == 2'b00) ? 1023 : int'(h);
    end
    e.lo = 16'((e.cur == 2'b00) ? r : r - 3);
    e.hi = 16'((e.cur == 2'b00) ? r : r + 3);
    q.push_back(e);
    apb(1'b1, tcr_pkg::ADDR_CTRL, {21'h000000, e.chan, 5'h00, u, v, 1'b1});
    if (poke) begin
      apb(1'b0, tcr_pkg::ADDR_STAT, 32'h00000000);
      chk("status busy", 1'b1, rd[tcr_pkg::STAT_BUSY]);
      apb(1'b1, tcr_pkg::ADDR_CTRL, {21'h000000, ~e.chan, 5'h00, 1'b1, ~v, 1'b1});
    end
    w = 0;
    while (q.size() != 0 && w < 30000) begin
      @(posedge pclk);
      w++;
    end
    if (w >= 30000) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  // watcher: pairs each done pulse with the oldest expectation
  always @(posedge pclk) begin
    if (pad_charge === 1'b1) chg_n = chg_n + 16'h0001;
    if (busy === 1'b1) begin
      chan_seen = pad_chan;
      if (osc_current !== 2'b00) cur_seen = osc_current;
      chk("pad analog", 1'b1, pad_analog);
    end
    if (done === 1'b1) begin
      chk("done pulse", 1'b0, dprev);
      chk("busy at done", 1'b0, busy);
      if (q.size() == 0) begin
        chk("spurious done", 1'b0, 1'b1);
      end else begin
        me = q.pop_front();
        chk_rng("result", me.lo, me.hi, result);
        chk("charge cycles", me.chg, chg_n);
        chk("current", me.cur, cur_seen);
        chk("channel", me.chan, chan_seen);
      end
      chg_n = 16'h0000;
      cur_seen = 2'b00;
    end
    dprev = done;
  end

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    half = 8'h04;
    n_errors = 0;
    checks = 0;
    chg_n = 16'h0000;
    cur_seen = 2'b00;
    chan_seen = 3'h0;
    dprev = 1'b0;
    pre = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
    chg_cfg = '{8'hD5, 8'h20, 8'h3F, 8'h05};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'hC46E));
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h00000000);
      chk("reset value", 32'h00000000, rd);
      chk("mapped", 1'b0, err);
    end
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk("unmapped write", 1'b1, err);
    apb(1'b0, 8'h10, 32'h00000000);
    chk("unmapped read", 32'h00000001, {31'h00000000, err});
    chk("unmapped data", 32'h00000000, rd);
    apb(1'b1, tcr_pkg::ADDR_CFG, 32'h000000A5);
    apb(1'b0, tcr_pkg::ADDR_CFG, 32'h00000000);
    chk("cfg readback", 8'hA5, rd[7:0]);
    measure(1'b0, 1'b0, 8'hFF, 8'h04, 1'b1);
    apb(1'b0, tcr_pkg::ADDR_STAT, 32'h00000000);
    chk("done sticky", 2'b10, rd[1:0]);
    apb(1'b1, tcr_pkg::ADDR_STAT, 32'h00000002);
    apb(1'b0, tcr_pkg::ADDR_STAT, 32'h00000000);
    chk("done cleared", 2'b00, rd[1:0]);
    for (int i = 0; i < 5; i++) begin
      measure(1'b0, 1'b1, {pre[i], 2'(i % 3 + 1), 3'($urandom % 4)}, 8'(3 + $urandom % 4),
        1'b0);
    end
    measure(1'b0, 1'b1, 8'h49, 8'h03, 1'b0);
    measure(1'b0, 1'b1, 8'h49, 8'h06, 1'b0);
    measure(1'b0, 1'b1, 8'hFF, 8'h40, 1'b0);
    measure(1'b1, 1'b0, 8'h00, 8'h05, 1'b1);
    for (int i = 0; i < 4; i++) begin
      measure(1'b1, 1'b1, chg_cfg[i], 8'(4 + $urandom % 4), 1'b0);
    end
    tally_and_finish();
  end
endmodule

// >>> design/tcr_ctl_if.sv
// control bundle between the readout sequencer and its counters
`timescale 1ns/10ps
interface tcr_ctl_if;
  logic       ce;
  logic       run;
  logic       osc_in;
  logic       tick;
  logic       reached;
  logic [2:0] div_code;
  logic [8:0] osc_req;
  modport ctl (output ce, run, osc_in, div_code, osc_req, input tick, reached);
  modport pre (input ce, run, div_code, output tick);
  modport edg (input ce, run, osc_in, osc_req, output reached);
endinterface

// >>> design/tcr_edge_cnt.sv
// counts rising edges of the sensor oscillator up to the required count
`timescale 1ns/10ps
module tcr_edge_cnt (
  input wire logic pclk,
  input wire logic presetn,
  tcr_ctl_if.edg   bus
);
  logic       osc_q;
  logic [8:0] cnt_reg;
  wire logic rise = bus.osc_in & ~osc_q;
  assign bus.reached = bus.run & (cnt_reg == bus.osc_req); // RL2
  // ==========================================================
  // edge count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_q   <= 1'b0;
      cnt_reg <= 9'h000;
    end else if (bus.ce) begin
      osc_q <= bus.osc_in;
      if (!bus.run) begin
        cnt_reg <= 9'h000;
      end else if (rise && !bus.reached) begin
        cnt_reg <= cnt_reg + 9'h001;
      end
    end
  end
endmodule

// >>> design/tcr_pkg.sv
// constants shared by the capacitive touch readout block
// Contract
// [RL1] word variant returns 16 bits, charge-time variant returns 10 bits (0..1023)
// [RL2] measure time for preset oscillation count; more capacitance gives larger value
// [RL3] word cfg bits 7:5 set required count 256,192,128,64,32; code uses 256 minus 32 per code step (256,224,...,32)
// [RL4] word cfg bits 4:3 pick source current off, low, medium, high
// [RL5] word cfg bits 2:0 pick timer prescale 2..256, code 001 divides by 4
// [RL6] word variant without cfg byte uses 000 01 001
// [RL7] charge variant ignores bits 7:6, bits 5:4 pick charge current
// [RL8] charge variant bits 3:0 set charge interval in 2us units, 1..15
// [RL9] charge variant without cfg byte uses 0011 0010
// [RL10] measurement counter runs from the system clock
// [RL11] pin switched to analog mode and attached to oscillator before measuring
// [RL12] busy from request until count completes, then result and one-cycle done
package tcr_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CFG    = 8'h04;
  localparam logic [7:0] ADDR_STAT   = 8'h08;
  localparam logic [7:0] ADDR_RES    = 8'h0C;
  localparam int         CTRL_START  = 0;
  localparam int         CTRL_VAR    = 1;
  localparam int         CTRL_USECFG = 2;
  localparam int         CTRL_CH_LSB = 8;
  localparam int         STAT_BUSY   = 0;
  localparam int         STAT_DONE   = 1;
  localparam logic [7:0] CFG_RST     = 8'h00;
  // ==========================================================
  // configuration byte layouts
  localparam logic [7:0] CFG_DEF_WORD  = 8'h09;
  localparam logic [7:0] CFG_DEF_CHG   = 8'h32;
  localparam int         WCFG_PRE_LSB  = 5;
  localparam int         WCFG_CUR_LSB  = 3;
  localparam int         WCFG_DIV_LSB  = 0;
  localparam int         CCFG_CUR_LSB  = 4;
  localparam int         CCFG_TIME_LSB = 0;
  localparam logic [8:0] OSC_FULL      = 9'h100;
  localparam int         OSC_STEP_SH   = 5;
  localparam logic [15:0] WORD_MAX     = 16'hFFFF;
  localparam logic [9:0] CHG_MAX       = 10'h3FF;
  // ==========================================================
  // timing
  localparam int         CLK_NS      = 100;
  localparam int         T_UNIT_NS   = 2000;
  localparam int         CYC_UNIT    = (T_UNIT_NS + CLK_NS - 1) / CLK_NS;
endpackage

// >>> design/tcr_prescale.sv
// timing prescaler, divides the system clock by 2^(code+1)
`timescale 1ns/10ps
module tcr_prescale (
  input wire logic pclk,
  input wire logic presetn,
  tcr_ctl_if.pre   bus
);
  logic [7:0] cnt_reg;
  wire logic [8:0] span = (9'h002 << bus.div_code) - 9'h001;
  wire logic [7:0] mask = span[7:0];
  assign bus.tick = bus.run & (cnt_reg == mask); // RL5
  // ==========================================================
  // divider count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
    end else if (bus.ce) begin
      cnt_reg <= (!bus.run || bus.tick) ? 8'h00 : cnt_reg + 8'h01;
    end
  end
endmodule

// >>> design/tcr_touch_readout.sv
// capacitive touch readout with apb registers
`timescale 1ns/10ps
module tcr_touch_readout (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_in,
  output logic             pad_analog,
  output logic      [2:0]  pad_chan,
  output logic      [1:0]  osc_current,
  output logic             pad_charge,
  output logic             busy,
  output logic             done,
  output logic      [15:0] result
);
  typedef enum {S_IDLE, S_ATTACH, S_CHARGE, S_MEAS} tcr_state_t;

  tcr_state_t  state_reg;
  tcr_state_t  state_next;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        ctrl_var_reg;
  logic        ctrl_use_reg;
  logic [2:0]  ctrl_ch_reg;
  logic [7:0]  cfg_reg;
  logic        done_stat_reg;
  logic        var_act_reg;
  logic [7:0]  cfg_act_reg;
  logic [15:0] timer_reg;
  logic [9:0]  chg_cnt_reg;
  logic        pad_analog_reg;
  logic [2:0]  pad_chan_reg;
  logic [1:0]  osc_current_reg;
  logic        pad_charge_reg;
  logic        busy_reg;
  logic        done_reg;
  logic [15:0] result_reg;
  logic [31:0] rd_mux;
  logic        finish;

  tcr_ctl_if cbus ();

  // ==========================================================
  // apb decode
  wire logic access   = psel & penable;
  wire logic take     = access & pready_reg;
  wire logic wr_en    = take & pwrite;
  wire logic hit_ctrl = (paddr == tcr_pkg::ADDR_CTRL);
  wire logic hit_cfg  = (paddr == tcr_pkg::ADDR_CFG);
  wire logic hit_stat = (paddr == tcr_pkg::ADDR_STAT);
  wire logic hit_res  = (paddr == tcr_pkg::ADDR_RES);
  wire logic addr_ok  = hit_ctrl | hit_cfg | hit_stat | hit_res;
  wire logic start_go = wr_en & hit_ctrl & pwdata[tcr_pkg::CTRL_START]
                        & (state_reg == S_IDLE);
  wire logic done_clr = wr_en & hit_stat & pwdata[tcr_pkg::STAT_DONE];
  wire logic var_in   = pwdata[tcr_pkg::CTRL_VAR];
  wire logic use_in   = pwdata[tcr_pkg::CTRL_USECFG];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[tcr_pkg::CTRL_VAR]           = ctrl_var_reg;
      rd_mux[tcr_pkg::CTRL_USECFG]        = ctrl_use_reg;
      rd_mux[tcr_pkg::CTRL_CH_LSB +: 3]   = ctrl_ch_reg;
    end else if (hit_cfg) begin
      rd_mux[7:0] = cfg_reg;
    end else if (hit_stat) begin
      rd_mux[tcr_pkg::STAT_BUSY] = busy_reg;
      rd_mux[tcr_pkg::STAT_DONE] = done_stat_reg;
    end else if (hit_res) begin
      rd_mux[15:0] = result_reg;
    end
  end

  // one wait state: answer registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (ce) begin
      pready_reg <= access & ~pready_reg;
      if (access && !pready_reg) begin
        pslverr_reg <= ~addr_ok;
        prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_var_reg  <= 1'b0;
      ctrl_use_reg  <= 1'b0;
      ctrl_ch_reg   <= 3'h0;
      cfg_reg       <= tcr_pkg::CFG_RST;
      done_stat_reg <= 1'b0;
    end else if (ce) begin
      if (wr_en && hit_ctrl) begin
        ctrl_var_reg <= var_in;
        ctrl_use_reg <= use_in;
        ctrl_ch_reg  <= pwdata[tcr_pkg::CTRL_CH_LSB +: 3];
      end
      if (wr_en && hit_cfg) begin
        cfg_reg <= pwdata[7:0];
      end
      // completion wins over a clear in the same cycle
      done_stat_reg <= finish | (done_stat_reg & ~done_clr); // RL12
    end
  end

  // ==========================================================
  // configuration fields
  wire logic [7:0] cfg_eff = use_in ? cfg_reg
                             : (var_in ? tcr_pkg::CFG_DEF_CHG : tcr_pkg::CFG_DEF_WORD); // RL6 RL9
  wire logic [2:0] w_pre  = cfg_act_reg[tcr_pkg::WCFG_PRE_LSB +: 3];
  wire logic [1:0] w_cur  = cfg_act_reg[tcr_pkg::WCFG_CUR_LSB +: 2];
  wire logic [2:0] w_div  = cfg_act_reg[tcr_pkg::WCFG_DIV_LSB +: 3];
  wire logic [1:0] c_cur  = cfg_act_reg[tcr_pkg::CCFG_CUR_LSB +: 2]; // RL7
  wire logic [3:0] c_time = cfg_act_reg[tcr_pkg::CCFG_TIME_LSB +: 4];
  // a zero interval is not valid, treated as one unit
  wire logic [3:0] c_mult = (c_time == 4'h0) ? 4'h1 : c_time; // RL8
  wire logic [9:0] chg_target = 10'(c_mult * tcr_pkg::CYC_UNIT); // RL8
  wire logic [9:0] chg_last   = chg_target - 10'h001;
  wire logic [1:0] sel_cur    = var_act_reg ? c_cur : w_cur; // RL4 RL7
  wire logic [8:0] word_req   = tcr_pkg::OSC_FULL
                                - (9'(w_pre) << tcr_pkg::OSC_STEP_SH); // RL3
  wire logic [15:0] timer_max = var_act_reg ? {6'h00, tcr_pkg::CHG_MAX}
                                : tcr_pkg::WORD_MAX; // RL1
  wire logic sat        = (timer_reg == timer_max);
  assign finish         = (state_reg == S_MEAS) & (cbus.reached | sat); // RL2
  wire logic timer_step = var_act_reg ? 1'b1 : cbus.tick; // RL10
  wire logic chg_end    = (state_reg == S_CHARGE) & (chg_cnt_reg == chg_last);

  // ==========================================================
  // counters
  assign cbus.ce       = ce;
  assign cbus.run      = (state_reg == S_MEAS);
  assign cbus.osc_in   = osc_in;
  assign cbus.div_code = w_div; // RL5
  assign cbus.osc_req  = var_act_reg ? 9'h001 : word_req; // RL3

  tcr_prescale u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (cbus)
  );

  tcr_edge_cnt u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (cbus)
  );

  // ==========================================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:   state_next = start_go ? S_ATTACH : S_IDLE;
      S_ATTACH: state_next = var_act_reg ? S_CHARGE : S_MEAS;
      S_CHARGE: state_next = chg_end ? S_MEAS : S_CHARGE;
      S_MEAS:   state_next = finish ? S_IDLE : S_MEAS;
      default:  state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= S_IDLE;
      var_act_reg <= 1'b0;
      cfg_act_reg <= 8'h00;
      timer_reg   <= 16'h0000;
      chg_cnt_reg <= 10'h000;
    end else if (ce) begin
      state_reg <= state_next;
      if (start_go) begin
        var_act_reg <= var_in;
        cfg_act_reg <= cfg_eff; // RL6 RL9
        timer_reg   <= 16'h0000;
      end else if (state_reg == S_MEAS && timer_step && !sat) begin
        timer_reg <= timer_reg + 16'h0001; // RL2 RL10
      end
      chg_cnt_reg <= (state_reg == S_CHARGE) ? chg_cnt_reg + 10'h001 : 10'h000;
    end
  end

  // ==========================================================
  // pin and status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_analog_reg  <= 1'b0;
      pad_chan_reg    <= 3'h0;
      osc_current_reg <= 2'h0;
      pad_charge_reg  <= 1'b0;
      busy_reg        <= 1'b0;
      done_reg        <= 1'b0;
      result_reg      <= 16'h0000;
    end else if (ce) begin
      done_reg <= finish; // RL12
      if (start_go) begin
        pad_analog_reg <= 1'b1; // RL11
        pad_chan_reg   <= pwdata[tcr_pkg::CTRL_CH_LSB +: 3];
        busy_reg       <= 1'b1; // RL12
      end else if (finish) begin
        pad_analog_reg <= 1'b0;
        busy_reg       <= 1'b0;
        result_reg     <= timer_reg; // RL1
      end
      if (state_reg == S_ATTACH) begin
        osc_current_reg <= sel_cur; // RL4 RL7 RL11
        pad_charge_reg  <= var_act_reg;
      end else if (finish) begin
        osc_current_reg <= 2'h0;
      end
      if (chg_end) begin
        pad_charge_reg <= 1'b0;
      end
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign pad_analog  = pad_analog_reg;
  assign pad_chan    = pad_chan_reg;
  assign osc_current = osc_current_reg;
  assign pad_charge  = pad_charge_reg;
  assign busy        = busy_reg;
  assign done        = done_reg;
  assign result      = result_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_busy_on_start: // RL12
    assert property (ce && start_go |=> busy && pad_analog)
      else $error("busy not raised after start");
  a_done_single: // RL12
    assert property (ce && done |=> !done)
      else $error("done longer than one cycle");
  a_done_ends_busy: // RL12
    assert property ($rose(done) |-> !busy && $past(busy))
      else $error("done without a busy period");
  a_chg_range: // RL1
    assert property (done && var_act_reg |-> result[15:10] == 6'h00)
      else $error("charge result above ten bits");
  a_req_smallest: // RL3
    assert property (cbus.run && !var_act_reg && w_pre == 3'h7 |-> cbus.osc_req == 9'h020)
      else $error("required count for 111 wrong");
  a_word_default: // RL6
    assert property (ce && start_go && !use_in && !var_in |=> cfg_act_reg == 8'h09)
      else $error("word default config wrong");
  a_chg_default: // RL9
    assert property (ce && start_go && !use_in && var_in |=> cfg_act_reg == 8'h32)
      else $error("charge default config wrong");
  a_meas_current: // RL4
    assert property (cbus.run && !var_act_reg |-> osc_current == cfg_act_reg[4:3])
      else $error("word current select wrong");
  a_chg_current: // RL7
    assert property (cbus.run && var_act_reg |-> osc_current == cfg_act_reg[5:4])
      else $error("charge current select wrong");
  a_meas_attached: // RL11
    assert property (cbus.run |-> pad_analog)
      else $error("measuring while pin not analog");
  a_charge_min: // RL8
    assert property ($rose(pad_charge) |-> pad_charge [*8])
      else $error("charge interval too short");
  a_tick_spacing: // RL5
    assert property (ce && cbus.tick |=> !cbus.tick)
      else $error("prescaler ticks back to back");
  a_sysclk_count: // RL10
    assert property (ce && cbus.run && var_act_reg && !finish
                     |=> timer_reg == $past(timer_reg) + 16'h0001)
      else $error("charge timer not counting system clock");
  a_done_sticky: // RL12
    assert property (ce && finish |=> done_stat_reg)
      else $error("done status not set on completion");
  a_result_hold: // RL1
    assert property (ce && !finish |=> $stable(result))
      else $error("result changed outside completion");

  c_word_done: cover property (done && !var_act_reg);
  c_chg_done: cover property (done && var_act_reg);
  c_saturate: cover property (finish && sat);
  c_clear_race: cover property (finish && done_clr);
  c_chg_off: cover property (done && var_act_reg && result == 16'h03FF);
endmodule
